// File: core/pss_control.sv
// Purpose: Sleep, setpoint selection and ramp, limits and monitors.
// Assumes: APB slave with no wait states; inputs synchronous to clk.
// Notes: Percent in 0.01 %, frequency in 0.1 Hz, sleep delay in 0.1 s ticks, ramp time in 1 s per 100 %.
//
// Register access over APB and the address map are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module pss_control #(
    parameter int TICK_LEN = pss_pkg::TICK_CYCLES
) (
    input wire logic clk,                      // System clock.
    input wire logic srst,                     // Synchronous reset.
    input wire logic psel,                     // APB select.
    input wire logic penable,                  // APB enable.
    input wire logic pwrite,                   // APB write.
    input wire logic [11:0] paddr,             // APB byte address.
    input wire logic [31:0] pwdata,            // APB write data.
    output logic [31:0] prdata,                // APB read data.
    output logic pready,                       // APB ready.
    output logic pslverr,                      // APB error.
    input wire logic [13:0] analog_setpoint,   // Analog setpoint.
    input wire logic [13:0] pulse_setpoint,    // Pulse setpoint.
    input wire logic setpoint_ramp_bypass,     // Ramp bypass input.
    input wire logic signed [17:0] ctl_in,     // Controller input.
    input wire logic signed [17:0] ctl_out,    // Controller output.
    input wire logic [15:0] freq_ref_in,       // Frequency reference.
    input wire logic [13:0] feedback_in,       // Feedback value.
    output logic [13:0] ctl_setpoint,          // Ramped setpoint.
    output logic signed [17:0] ctl_in_limited, // Clamped input.
    output logic [15:0] freq_ref_out,          // Reference to ramps.
    output logic reverse_run,                  // Reverse direction.
    output logic sleep_stop,                   // Stop for sleep.
    output logic [1:0] stop_method_out         // Stop method in use.
);
    import pss_pkg::*;

    // ************************************************************
    // State
    // ************************************************************
    typedef struct packed {
        logic [2:0] mode;
        logic src_sel;
        logic rev2;
        logic rev_prohibit;
        logic mon_content;
        logic [1:0] stop_method;
        logic [1:0] scaling;
        logic [1:0] user_digits;
        logic [1:0] ext_src;
        logic [11:0] sleep_level;
        logic [7:0] sleep_delay;
        logic [7:0] ramp_time;
        logic [13:0] stored_sp;
        logic signed [15:0] lower_limit;
        logic [16:0] input_limit;
        logic [15:0] user_display;
        logic [15:0] max_freq;
        logic [13:0] modbus_sp;
        logic [31:0] prdata;
        logic [31:0] tick_cnt;
        logic tick;
        logic [13:0] sp_ramped;
        logic signed [17:0] in_lim;
        logic [15:0] freq_out;
        logic reverse;
        logic [15:0] ref_mon;
        logic [15:0] sp_mon;
        logic [15:0] fb_mon;
    } pss_state_t;

    pss_state_t q_reg;
    pss_state_t q_next;
    pss_sleep_if sl ();

    // ************************************************************
    // Functions
    // ************************************************************
    // Scales a percent value against a full-scale value.
    function automatic logic [15:0] scale(input logic [13:0] pct,
                                          input logic [15:0] full);
        logic [31:0] p;
        p = (32'(pct) * 32'(full)) / 32'(FULL_PCT);
        return p[15:0];
    endfunction

    // Converts a percent to the units the scaling selects.
    function automatic logic [15:0] disp(input logic [13:0] pct,
                                         input logic [1:0] scl,
                                         input logic [15:0] maxf,
                                         input logic [15:0] user);
        logic [15:0] r;
        r = 16'(pct);
        unique case (scl)
            SCL_HZ: r = 16'(32'(scale(pct, maxf)) * 32'd10);
            SCL_PCT: r = 16'(pct);
            SCL_RPM: r = scale(pct, RPM_AT_MAX);
            default: r = scale(pct, user);
        endcase
        return r;
    endfunction

    function automatic logic [13:0] sat_pct(input logic signed [17:0] v);
        logic [17:0] m;
        m = v[17] ? 18'(-v) : 18'(v);
        return (m > 18'(FULL_PCT)) ? FULL_PCT : m[13:0];
    endfunction

    // ************************************************************
    // Register bus
    // ************************************************************
    logic wr_en;
    logic setup_rd;
    logic mapped;
    logic [31:0] rd_val;
    logic [7:0] status;
    logic [1:0] digits;

    assign wr_en = psel && penable && pwrite;
    assign setup_rd = psel && !penable && !pwrite;
    assign mapped = (paddr <= OFF_FB_MON) && (paddr[1:0] == 2'h0);

    always_comb begin
        unique case (q_reg.scaling)
            SCL_HZ: digits = DIG_HZ;
            SCL_PCT: digits = DIG_PCT;
            SCL_RPM: digits = DIG_RPM;
            default: digits = q_reg.user_digits;
        endcase
        status = {2'h0, digits, q_reg.stop_method,
                  q_reg.reverse, sl.asleep};
    end

    always_comb begin
        rd_val = 32'h0;
        unique case (paddr)
            OFF_CTRL: rd_val = {16'h0, q_reg.ext_src, q_reg.user_digits,
                                q_reg.scaling, q_reg.stop_method, 1'b0,
                                q_reg.mon_content, q_reg.rev_prohibit,
                                q_reg.rev2, q_reg.src_sel, q_reg.mode};
            OFF_SLEEP_LEVEL: rd_val = 32'(q_reg.sleep_level);
            OFF_SLEEP_DELAY: rd_val = 32'(q_reg.sleep_delay);
            OFF_RAMP_TIME: rd_val = 32'(q_reg.ramp_time);
            OFF_STORED_SP: rd_val = 32'(q_reg.stored_sp);
            OFF_LOWER_LIMIT: rd_val = 32'(q_reg.lower_limit);
            OFF_INPUT_LIMIT: rd_val = 32'(q_reg.input_limit);
            OFF_USER_DISPLAY: rd_val = 32'(q_reg.user_display);
            OFF_MAX_FREQ: rd_val = 32'(q_reg.max_freq);
            OFF_MODBUS_SP: rd_val = 32'(q_reg.modbus_sp);
            OFF_STATUS: rd_val = 32'(status);
            OFF_SP_MON: rd_val = 32'(q_reg.sp_mon);
            OFF_REF_MON: rd_val = 32'(q_reg.ref_mon);
            OFF_FB_MON: rd_val = 32'(q_reg.fb_mon);
            default: rd_val = 32'h0;
        endcase
    end

    // ************************************************************
    // Datapath
    // ************************************************************
    logic [13:0] target;
    logic [13:0] step;
    logic signed [17:0] lim;
    logic signed [17:0] out_c;
    logic signed [17:0] out_hz;
    logic signed [17:0] ref_s;
    logic signed [17:0] f;
    logic signed [17:0] pre_f;
    logic [15:0] cmp;
    logic trim;

    always_comb begin
        q_next = q_reg;
        // Read data is caught in the setup cycle, shown in the access.
        if (setup_rd) begin
            q_next.prdata = rd_val;
        end
        if (wr_en && mapped) begin
            unique case (paddr)
                OFF_CTRL: begin
                    q_next.mode = pwdata[2:0];
                    q_next.src_sel = pwdata[3];
                    q_next.rev2 = pwdata[4];
                    q_next.rev_prohibit = pwdata[5];
                    q_next.mon_content = pwdata[6];
                    q_next.stop_method = pwdata[9:8];
                    q_next.scaling = pwdata[11:10];
                    q_next.user_digits = pwdata[13:12];
                    q_next.ext_src = pwdata[15:14];
                end
                OFF_SLEEP_LEVEL: q_next.sleep_level =
                    (pwdata[11:0] > MAX_SLEEP_LEVEL) ?
                    MAX_SLEEP_LEVEL : pwdata[11:0];
                OFF_SLEEP_DELAY: q_next.sleep_delay = pwdata[7:0];
                OFF_RAMP_TIME: q_next.ramp_time = pwdata[7:0];
                OFF_STORED_SP: q_next.stored_sp = pwdata[13:0];
                OFF_LOWER_LIMIT: q_next.lower_limit = pwdata[15:0];
                OFF_INPUT_LIMIT: q_next.input_limit = pwdata[16:0];
                OFF_USER_DISPLAY: q_next.user_display = pwdata[15:0];
                OFF_MAX_FREQ: q_next.max_freq = pwdata[15:0];
                OFF_MODBUS_SP: q_next.modbus_sp = pwdata[13:0];
                default: q_next.mode = q_reg.mode;
            endcase
        end

        // A 0.1 s tick paces the delay timer and the ramp.
        q_next.tick = 1'b0;
        if (q_reg.tick_cnt >= 32'(TICK_LEN - 1)) begin
            q_next.tick_cnt = 32'h0;
            q_next.tick = 1'b1;
        end else begin
            q_next.tick_cnt = q_reg.tick_cnt + 32'h1;
        end

        // Setpoint source and ramp.
        if (q_reg.src_sel) begin
            target = q_reg.stored_sp;
        end else if (q_reg.ext_src == SRC_ANALOG) begin
            target = analog_setpoint;
        end else if (q_reg.ext_src == SRC_PULSE) begin
            target = pulse_setpoint;
        end else begin
            target = q_reg.modbus_sp;
        end
        step = (q_reg.ramp_time == 8'h0) ? 14'h1 :
               14'(16'h03e8 / 16'(q_reg.ramp_time));
        if (step == 14'h0) begin
            step = 14'h1;
        end
        if (setpoint_ramp_bypass || q_reg.ramp_time == 8'h0) begin
            q_next.sp_ramped = target;
        end else if (q_reg.tick) begin
            if (target > q_reg.sp_ramped) begin
                q_next.sp_ramped = (target - q_reg.sp_ramped > step) ?
                    q_reg.sp_ramped + step : target;
            end else begin
                q_next.sp_ramped = (q_reg.sp_ramped - target > step) ?
                    q_reg.sp_ramped - step : target;
            end
        end

        // Symmetric clamp on the controller input.
        lim = 18'(q_reg.input_limit);
        if (ctl_in > lim) begin
            q_next.in_lim = lim;
        end else if (ctl_in < -lim) begin
            q_next.in_lim = -lim;
        end else begin
            q_next.in_lim = ctl_in;
        end

        // Controller output, lower limit and conversion to 0.1 Hz.
        out_c = ctl_out;
        if (q_reg.lower_limit != 16'sh0 &&
            out_c < 18'(q_reg.lower_limit)) begin
            out_c = 18'(q_reg.lower_limit);
        end
        out_hz = 18'(scale(sat_pct(out_c), q_reg.max_freq));
        if (out_c < 0) begin
            out_hz = -out_hz;
        end
        trim = (q_reg.mode == MODE_TRIM_A) || (q_reg.mode == MODE_TRIM_B);
        if (out_c < 0 && trim && !q_reg.rev2) begin
            out_hz = 18'sh0;
        end
        ref_s = 18'(freq_ref_in);
        if (q_reg.mode == MODE_OFF) begin
            pre_f = ref_s;
        end else if (trim) begin
            pre_f = ref_s + out_hz;
        end else begin
            pre_f = out_hz;
        end
        f = pre_f;
        if (f < 0 && q_reg.rev_prohibit) begin
            f = 18'sh0;
        end
        q_next.reverse = (f < 0);
        // Output goes to the normal ramps, which act downstream.
        q_next.freq_out = sl.asleep ? 16'h0 :
                          (f < 0 ? 16'(-f) : 16'(f));

        // Sleep compares the reference with the controller off.
        cmp = (q_reg.mode == MODE_OFF) ? freq_ref_in :
              (out_hz < 0 ? 16'(-out_hz) : 16'(out_hz));

        // Monitors.
        q_next.ref_mon = (q_reg.mode != MODE_OFF && !q_reg.mon_content) ?
            (pre_f < 0 ? 16'(-pre_f) : 16'(pre_f)) : freq_ref_in;
        q_next.sp_mon = disp(q_reg.sp_ramped, q_reg.scaling,
                             q_reg.max_freq, q_reg.user_display);
        q_next.fb_mon = disp(feedback_in, q_reg.scaling,
                             q_reg.max_freq, q_reg.user_display);
    end

    assign sl.tick = q_reg.tick;
    assign sl.below = (cmp < 16'(q_reg.sleep_level));
    assign sl.delay = q_reg.sleep_delay;

    pss_sleep_timer u_timer (
        .clk(clk),
        .srst(srst),
        .sl(sl)
    );

    // ************************************************************
    // Registers
    // ************************************************************
    always_ff @(posedge clk) begin
        if (srst) begin
            q_reg <= '0;
            q_reg.rev2 <= RST_REV2;
            q_reg.scaling <= RST_SCALING;
            q_reg.input_limit <= RST_INPUT_LIMIT;
            q_reg.max_freq <= RST_MAX_FREQ;
            q_reg.user_display <= RST_USER_DISPLAY;
        end else begin
            q_reg <= q_next;
        end
    end

    assign prdata = q_reg.prdata;
    assign pready = 1'b1;
    assign pslverr = psel && penable && !mapped;
    assign ctl_setpoint = q_reg.sp_ramped;
    assign ctl_in_limited = q_reg.in_lim;
    assign freq_ref_out = q_reg.freq_out;
    assign reverse_run = q_reg.reverse;
    assign sleep_stop = sl.asleep;
    assign stop_method_out = q_reg.stop_method;
endmodule
`default_nettype wire

// File: core/pss_pkg.sv
// Purpose: Constants and types for the controller sleep and setpoint block.
// Assumes: 250 MHz clock, APB register access, one word per register.
// Notes: Percent values are in 0.01 %, frequencies in 0.1 Hz.
package pss_pkg;

    // ************************************************************
    // Timing
    // ************************************************************
    localparam int CLK_KHZ = 250000;
    localparam int TICK_MS = 100;
    localparam int TICK_CYCLES = TICK_MS * CLK_KHZ;

    // ************************************************************
    // Register offsets
    // ************************************************************
    localparam logic [11:0] OFF_CTRL = 12'h000;
    localparam logic [11:0] OFF_SLEEP_LEVEL = 12'h004;
    localparam logic [11:0] OFF_SLEEP_DELAY = 12'h008;
    localparam logic [11:0] OFF_RAMP_TIME = 12'h00c;
    localparam logic [11:0] OFF_STORED_SP = 12'h010;
    localparam logic [11:0] OFF_LOWER_LIMIT = 12'h014;
    localparam logic [11:0] OFF_INPUT_LIMIT = 12'h018;
    localparam logic [11:0] OFF_USER_DISPLAY = 12'h01c;
    localparam logic [11:0] OFF_MAX_FREQ = 12'h020;
    localparam logic [11:0] OFF_MODBUS_SP = 12'h024;
    localparam logic [11:0] OFF_STATUS = 12'h028;
    localparam logic [11:0] OFF_SP_MON = 12'h02c;
    localparam logic [11:0] OFF_REF_MON = 12'h030;
    localparam logic [11:0] OFF_FB_MON = 12'h034;

    // ************************************************************
    // Reset values and limits
    // ************************************************************
    localparam logic [1:0] RST_SCALING = 2'h1;
    localparam logic RST_REV2 = 1'h1;
    localparam logic [16:0] RST_INPUT_LIMIT = 17'h186a0;
    localparam logic [15:0] RST_MAX_FREQ = 16'h0258;
    localparam logic [15:0] RST_USER_DISPLAY = 16'h2710;
    localparam logic [11:0] MAX_SLEEP_LEVEL = 12'hfa0;
    localparam logic [13:0] FULL_PCT = 14'h2710;
    localparam logic [15:0] RPM_AT_MAX = 16'h0708;

    // ************************************************************
    // Enumerations
    // ************************************************************
    localparam logic [2:0] MODE_OFF = 3'h0;
    localparam logic [2:0] MODE_TRIM_A = 3'h3;
    localparam logic [2:0] MODE_TRIM_B = 3'h4;
    localparam logic [1:0] SRC_ANALOG = 2'h0;
    localparam logic [1:0] SRC_PULSE = 2'h1;
    localparam logic [1:0] SCL_HZ = 2'h0;
    localparam logic [1:0] SCL_PCT = 2'h1;
    localparam logic [1:0] SCL_RPM = 2'h2;
    localparam logic [1:0] DIG_HZ = 2'h2;
    localparam logic [1:0] DIG_PCT = 2'h2;
    localparam logic [1:0] DIG_RPM = 2'h0;

    typedef enum logic {SLP_AWAKE = 1'b0, SLP_ASLEEP = 1'b1} pss_sleep_t;

endpackage

// File: core/pss_sleep_if.sv
// Purpose: Carries the sleep comparison between top and delay timer.
// Assumes: One clock domain.
// Notes: Delay counts 0.1 s ticks.
`timescale 1ns/1ps
`default_nettype none
interface pss_sleep_if;
    logic tick;
    logic below;
    logic [7:0] delay;
    logic asleep;
    modport ctrl (output tick, output below, output delay, input asleep);
    modport timer (input tick, input below, input delay, output asleep);
endinterface
`default_nettype wire

// File: core/pss_sleep_timer.sv
// Purpose: Sleep state with a common entry and exit delay.
// Assumes: Tick is a one-cycle pulse every 0.1 s.
// Notes: The state changes on the tick after delay ticks that disagree with it.
`timescale 1ns/1ps
`default_nettype none
module pss_sleep_timer (
    input wire logic clk,          // System clock.
    input wire logic srst,         // Synchronous reset.
    pss_sleep_if.timer sl          // Comparison and sleep state.
);
    import pss_pkg::*;

    typedef struct packed {
        pss_sleep_t state;
        logic [7:0] cnt;
    } pss_tmr_t;

    pss_tmr_t q_reg;
    pss_tmr_t q_next;

    always_comb begin
        q_next = q_reg;
        // A condition that agrees with the state clears the count.
        if ((q_reg.state == SLP_ASLEEP) == sl.below) begin
            q_next.cnt = 8'h00;
        end else if (sl.tick) begin
            if (q_reg.cnt == sl.delay) begin
                q_next.cnt = 8'h00;
                unique case (q_reg.state)
                    SLP_AWAKE: q_next.state = SLP_ASLEEP;
                    SLP_ASLEEP: q_next.state = SLP_AWAKE;
                endcase
            end else begin
                q_next.cnt = q_reg.cnt + 8'h01;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            q_reg <= '{state: SLP_AWAKE, cnt: 8'h00};
        end else begin
            q_reg <= q_next;
        end
    end

    assign sl.asleep = (q_reg.state == SLP_ASLEEP);
endmodule
`default_nettype wire

// File: sim/pss_control_assertions.sv
// Purpose: Port checks for the sleep and setpoint block.
// Assumes: One clock, synchronous active-high reset.
// Notes: Attached by the bind at the foot.
`timescale 1ns/1ps
`default_nettype none
module pss_control_assertions #(
    parameter int TICK_LEN = 4
) (
    input wire logic clk, // Clock.
    input wire logic srst, // Reset.
    input wire logic psel, // Select.
    input wire logic penable, // Enable.
    input wire logic pwrite, // Write.
    input wire logic [11:0] paddr, // Address.
    input wire logic [31:0] prdata, // Read data.
    input wire logic pready, // Ready.
    input wire logic pslverr, // Error.
    input wire logic signed [17:0] ctl_in, // Input.
    input wire logic signed [17:0] ctl_in_limited, // Clamped input.
    input wire logic [15:0] freq_ref_out, // Reference.
    input wire logic sleep_stop, // Sleep.
    input wire logic [1:0] stop_method_out // Stop method.
);
    // ******************
    // Properties
    // ******************
    default clocking @(posedge clk);
    endclocking
    default disable iff (srst);
    sequence s_acc;
        psel && penable;
    endsequence
    sequence s_calm;
        $stable(sleep_stop) [*3];
    endsequence
    a_ready_high: assert property (s_acc |-> pready)
        else $error("pready low in access");
    a_err_bad: assert property (psel && penable && (paddr > 12'h034 ||
        paddr[1:0] != 2'h0) |-> pslverr) else $error("bad address no error");
    a_err_good: assert property (psel && penable && paddr <= 12'h034 &&
        paddr[1:0] == 2'h0 |-> !pslverr) else $error("good address error");
    a_err_where: assert property (pslverr |-> s_acc)
        else $error("error outside access");
    a_rdata_hold: assert property ($changed(prdata) |-> $past(psel && !penable))
        else $error("read data moved");
    a_sleep_zero: assert property (
        sleep_stop && $past(sleep_stop) |-> freq_ref_out == 16'h0000)
        else $error("reference while asleep");
    a_sleep_tick: assert property ($changed(sleep_stop) |=> s_calm)
        else $error("sleep state off tick");
    a_clamp_sign: assert property (
        ctl_in_limited != 18'h00000 |-> ctl_in_limited[17] == $past(ctl_in[17]))
        else $error("clamp flipped sign");
    a_stop_write: assert property ($changed(stop_method_out) |->
        $past(psel && penable && pwrite) || $past(psel && penable && pwrite, 2))
        else $error("stop method moved alone");
endmodule
bind pss_control pss_control_assertions #(.TICK_LEN(TICK_LEN)) u_chk (
    .clk(clk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ctl_in(ctl_in), .ctl_in_limited(ctl_in_limited),
    .freq_ref_out(freq_ref_out), .sleep_stop(sleep_stop),
    .stop_method_out(stop_method_out)
);
`default_nettype wire

// File: sim/pss_drive_model.sv
// Purpose: Reference path and stop sequencer beyond the block.
// Assumes: Reference in 0.1 Hz, one step of ramp per cycle.
// Notes: Any stop method other than 0 coasts at once.
`timescale 1ns/1ps
`default_nettype none
module pss_drive_model #(
    parameter logic [15:0] STEP = 16'h0010
) (
    input wire logic clk, // Clock.
    input wire logic srst, // Reset.
    input wire logic [15:0] freq_ref_out, // Target reference.
    input wire logic sleep_stop, // Sleep stop request.
    input wire logic [1:0] stop_method_out, // Stop method.
    output logic [15:0] out_freq // Output frequency.
);
    // ******************
    // Ramp and stop
    // ******************
    always_ff @(posedge clk) begin
        if (srst) begin
            out_freq <= 16'h0000;
        end else if (sleep_stop && stop_method_out != 2'h0) begin
            out_freq <= 16'h0000;
        end else if (out_freq + STEP < freq_ref_out) begin
            out_freq <= out_freq + STEP;
        end else if (out_freq > freq_ref_out + STEP) begin
            out_freq <= out_freq - STEP;
        end else begin
            out_freq <= freq_ref_out;
        end
    end
endmodule
`default_nettype wire

// File: sim/test_pid_sleep_setpoint_control.sv
// Purpose: Self-checking bench for the sleep and setpoint block.
// Assumes: Tick shortened to 4 cycles.
// Notes: Outputs are read 1 ns after an edge by cyc; the APB task samples at the edge.
`timescale 1ns/1ps
`default_nettype none
module test_pid_sleep_setpoint_control;
    import pss_pkg::*;
    logic clk = 1'h0;
    logic srst = 1'h1;
    logic psel = 1'h0, penable = 1'h0, pwrite = 1'h0, e, bypass = 1'h0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, q;
    logic pready, pslverr, reverse_run, sleep_stop;
    logic [13:0] analog = 14'h0, pulse = 14'h0, ctl_setpoint;
    logic signed [17:0] ctl_in = 18'h0, ctl_out = 18'h0, ctl_in_limited;
    logic [15:0] freq_ref_in = 16'h0, freq_ref_out, out_freq;
    logic [1:0] stop_method_out;
    int failures = 0, compares = 0;
    // ******************
    // Design and far side
    // ******************
    pss_control #(.TICK_LEN(4)) dut (
        .clk(clk), .srst(srst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .analog_setpoint(analog),
        .pulse_setpoint(pulse), .setpoint_ramp_bypass(bypass),
        .ctl_in(ctl_in), .ctl_out(ctl_out), .freq_ref_in(freq_ref_in),
        .feedback_in(14'h0000), .ctl_setpoint(ctl_setpoint),
        .ctl_in_limited(ctl_in_limited), .freq_ref_out(freq_ref_out),
        .reverse_run(reverse_run), .sleep_stop(sleep_stop),
        .stop_method_out(stop_method_out)
    );
    pss_drive_model u_drive (
        .clk(clk), .srst(srst), .freq_ref_out(freq_ref_out),
        .sleep_stop(sleep_stop), .stop_method_out(stop_method_out),
        .out_freq(out_freq)
    );
    initial forever #2 clk = ~clk;
    task automatic results;
        if (failures == 0 && compares > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
        compares++;
        if (g !== x) begin
            failures++;
            $display("unexpected %s: expected %h, seen %h", n, x, g);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'h1;
        @(posedge clk);
        for (int i = 0; pready !== 1'h1; i++) begin
            if (i > 20) begin
                failures++;
                results();
            end
            @(posedge clk);
        end
        q = prdata;
        e = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'h1, a, d);
    endtask
    task automatic rdc(input logic [11:0] a, input logic [31:0] x);
        apb(1'h0, a, 32'h0);
        chk("register", x, q);
    endtask
    task automatic await(input logic v);
        for (int i = 0; i < 40 && sleep_stop !== v; i++) cyc(1);
        chk("sleep_stop", {31'h0, v}, {31'h0, sleep_stop});
        if (sleep_stop !== v) results();
    endtask
    // ******************
    // Scenarios
    // ******************
    task automatic t_reset;
        rdc(OFF_CTRL, 32'h0000_0410);
        rdc(OFF_INPUT_LIMIT, 32'h0001_86a0);
        rdc(OFF_SLEEP_LEVEL, 32'h0);
        rdc(OFF_SLEEP_DELAY, 32'h0);
        rdc(OFF_RAMP_TIME, 32'h0);
        rdc(OFF_LOWER_LIMIT, 32'h0);
        apb(1'h0, 12'h038, 32'h0);
        chk("pslverr", 32'h1, {31'h0, e});
        chk("sleep_stop", 32'h0, {31'h0, sleep_stop});
    endtask
    task automatic t_source;
        @(posedge clk);
        bypass <= 1'h1;
        analog <= 14'h04d2;
        pulse <= 14'h08ae;
        wr(OFF_STORED_SP, 32'h1388);
        cyc(3);
        chk("setpoint", 32'h4d2, 32'(ctl_setpoint));
        wr(OFF_CTRL, 32'h418);
        cyc(3);
        chk("setpoint", 32'h1388, 32'(ctl_setpoint));
        wr(OFF_CTRL, 32'h1c18);
        rdc(OFF_STATUS, 32'h10);
        rdc(OFF_SP_MON, 32'h1388);
        wr(OFF_CTRL, 32'h4410);
        cyc(3);
        chk("setpoint", 32'h8ae, 32'(ctl_setpoint));
        wr(OFF_MODBUS_SP, 32'h777);
        wr(OFF_CTRL, 32'h8410);
        cyc(3);
        chk("setpoint", 32'h777, 32'(ctl_setpoint));
        wr(OFF_CTRL, 32'h410);
    endtask
    task automatic t_ramp;
        wr(OFF_RAMP_TIME, 32'h1);
        @(posedge clk);
        bypass <= 1'h0;
        analog <= 14'h1388;
        cyc(6);
        chk("ramping", 32'h1, 32'(ctl_setpoint <= 14'h0ca2));
        cyc(30);
        chk("setpoint", 32'h1388, 32'(ctl_setpoint));
        @(posedge clk);
        bypass <= 1'h1;
        analog <= 14'h0;
        cyc(2);
        chk("setpoint", 32'h0, 32'(ctl_setpoint));
    endtask
    task automatic t_clamp;
        wr(OFF_INPUT_LIMIT, 32'h7d0);
        ctl_in <= 18'h01388;
        cyc(2);
        chk("clamp", 32'h7d0, 32'(ctl_in_limited));
        @(posedge clk);
        ctl_in <= 18'h3ec78;
        cyc(2);
        chk("clamp", 32'hfffff830, 32'(ctl_in_limited));
        @(posedge clk);
        ctl_in <= 18'h3ff9c;
        cyc(2);
        chk("clamp", 32'hffffff9c, 32'(ctl_in_limited));
    endtask
    task automatic t_sleep;
        wr(OFF_CTRL, 32'h610);
        freq_ref_in <= 16'h01f4;
        wr(OFF_SLEEP_LEVEL, 32'h64);
        wr(OFF_SLEEP_DELAY, 32'h2);
        freq_ref_in <= 16'h0032;
        repeat (6) @(posedge clk);
        freq_ref_in <= 16'h01f4;
        repeat (2) @(posedge clk);
        freq_ref_in <= 16'h0032;
        cyc(7);
        chk("sleep_stop", 32'h0, {31'h0, sleep_stop});
        await(1'h1);
        cyc(2);
        chk("freq_ref_out", 32'h0, 32'(freq_ref_out));
        chk("stop_method", 32'h2, 32'(stop_method_out));
        chk("out_freq", 32'h0, 32'(out_freq));
        @(posedge clk);
        freq_ref_in <= 16'h01f4;
        cyc(7);
        chk("sleep_stop", 32'h1, {31'h0, sleep_stop});
        await(1'h0);
        cyc(2);
        chk("freq_ref_out", 32'h1f4, 32'(freq_ref_out));
        wr(OFF_SLEEP_LEVEL, 32'h0);
    endtask
    task automatic t_trim;
        wr(OFF_CTRL, 32'h413);
        freq_ref_in <= 16'h012c;
        ctl_out <= 18'h003e8;
        cyc(3);
        chk("freq_ref_out", 32'h168, 32'(freq_ref_out));
        rdc(OFF_REF_MON, 32'h168);
        @(posedge clk);
        ctl_out <= 18'h3d8f0;
        cyc(3);
        chk("freq_ref_out", 32'h12c, 32'(freq_ref_out));
        chk("reverse_run", 32'h1, {31'h0, reverse_run});
        wr(OFF_CTRL, 32'h433);
        cyc(3);
        chk("freq_ref_out", 32'h0, 32'(freq_ref_out));
        wr(OFF_CTRL, 32'h404);
        cyc(3);
        chk("freq_ref_out", 32'h12c, 32'(freq_ref_out));
        chk("reverse_run", 32'h0, {31'h0, reverse_run});
        wr(OFF_LOWER_LIMIT, 32'hf060);
        wr(OFF_CTRL, 32'h414);
        cyc(3);
        chk("freq_ref_out", 32'h3c, 32'(freq_ref_out));
    endtask
    initial begin
        repeat (6) @(posedge clk);
        srst <= 1'h0;
        t_reset();
        t_source();
        t_ramp();
        t_clamp();
        t_sleep();
        t_trim();
        results();
    end
endmodule
`default_nettype wire
